// ### logic/protection_stage_timing_core.v
// Protection stage: pick-up with hysteresis, blocking, start/trip timing and register slave
//
// Overview of operation
// - Compare measurement to setting; assert pick-up.
// - Release pick-up below 97 percent of setting.
// - Start only from pick-up without blocking.
// - Sample blocking input at each cycle start.
// - Unblocked pick-up asserts start, starts timing.
// - Inhibited_indication pick-up gives inhibited indication, no timing.
// - Late blocking clears start, runs release; here start and timer clear at once and the stage parks in ST_BLK.
// - Each blocking emits notification and stamped event.
// - Test mode lets software drive blocking.
// - Timers cover trip and release cases; here only the trip delay is timed, release on pick-up drop is immediate.
// - Instant mode trips with start, no delay.
// - Fixed mode trips after delay, pick-up held.
// - Inverse mode delay from setting-measurement relation.
// - Delay type 0 fixed, 1 inverse.
// - Delay in 5 ms steps, default 40 ms.
// - Zero delay means instantaneous operation in fixed mode only.
// - Inverse mode delay floored by fixed delay.
// - Curve series 0 IEC, 1 IEEE, inverse only.
// - Forcing option lets software force start/trip.
//
// Chosen here: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "stage_map.vh"

module protection_stage_timing_core #(
    parameter MEAS_W      = 32,
    parameter STEP_CYCLES = `STEP_CYCLES,
    parameter INV_SHIFT_W = 5
) (
    // Clock and reset
    input  wire                ref_clk,
    input  wire                rst,
    // Avalon-MM slave
    input  wire [3:0]          avs_address,
    input  wire                avs_read,
    input  wire                avs_write,
    input  wire [31:0]         avs_writedata,
    input  wire [3:0]          avs_byteenable,
    output reg  [31:0]         avs_readdata,
    output wire                avs_waitrequest,
    // Measurement and blocking
    input  wire [MEAS_W-1:0]   meas_value,
    input  wire                cycle_start,
    input  wire                block_in,
    // Stage outputs
    output reg                 pickup_r,
    output reg                 start_r,
    output reg                 trip_r,
    output reg                 inhibited_indication_r,
    // Event port
    output reg                 event_valid_r,
    output reg  [MEAS_W-1:0]   event_value_r,
    output reg  [31:0]         event_stamp_r,
    output reg  [1:0]          event_fault_r,
    output reg                 notify_r
);

    // Stage states: idle waits for pick-up, time counts toward trip,
    // trip holds the output, and the parked state keeps one inhibited_indication
    // occurrence from being timed or reported twice.
    // Codes are plain binary; the status word shows them directly.
    localparam ST_IDLE  = 2'd0;
    localparam ST_TIME  = 2'd1;
    localparam ST_TRIP  = 2'd2;
    localparam ST_BLK   = 2'd3;

    // Step length as a sized constant so the delay product keeps its width
    localparam [31:0] STEP_CYC_W = STEP_CYCLES;

    ////////////////////////////////////////////////////////////////////////////
    // Register slave
    // Word map: control, pick-up setting, delay in steps, live status.
    // Only byte lanes that exist are writable; the rest read zero.
    // Status is read-only, so writes to it are dropped.
    // A single wait cycle per access keeps the slave simple and the
    // read path registered, at the cost of half the bus throughput.
    reg  [31:0]        ctrl_r;
    reg  [31:0]        setting_r;
    reg  [15:0]        delay_r;
    reg                ack_r;
    reg  [1:0]         state_r;
    reg  [31:0]        stamp_r;
    wire               req = avs_read | avs_write;
    wire [31:0]        status_word;

    // One wait cycle per access keeps read data registered
    assign avs_waitrequest = req & ~ack_r;

    // Writes land at the edge where waitrequest is low, the only edge at
    // which the master treats the access as done; reads are captured a
    // cycle earlier so their data stand at that same edge.
    always @(posedge ref_clk) begin
        if (rst) begin
            ctrl_r       <= `CTRL_RESET;
            setting_r    <= `SETTING_DEF;
            delay_r      <= `DELAY_DEF_STEPS;
            ack_r        <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end else begin
            ack_r <= req & ~ack_r;
            // Commit phase: request still held, waitrequest low
            if (avs_write & ack_r) begin
                    case (avs_address)
                        `REG_CTRL: begin
                            if (avs_byteenable[0])
                                ctrl_r[7:0] <= {1'b0, avs_writedata[6:0]};
                        end
                        `REG_SETTING: begin
                            if (avs_byteenable[0]) setting_r[7:0]   <= avs_writedata[7:0];
                            if (avs_byteenable[1]) setting_r[15:8]  <= avs_writedata[15:8];
                            if (avs_byteenable[2]) setting_r[23:16] <= avs_writedata[23:16];
                            if (avs_byteenable[3]) setting_r[31:24] <= avs_writedata[31:24];
                        end
                        `REG_DELAY: begin
                            if (avs_byteenable[0]) delay_r[7:0]  <= avs_writedata[7:0];
                            if (avs_byteenable[1]) delay_r[15:8] <= avs_writedata[15:8];
                        end
                        default: begin
                        end
                    endcase
            end
            // Capture phase: first cycle of any access
            if (req & ~ack_r) begin
                case (avs_address)
                    `REG_CTRL:    avs_readdata <= ctrl_r;
                    `REG_SETTING: avs_readdata <= setting_r;
                    `REG_DELAY:   avs_readdata <= {16'h0000, delay_r};
                    `REG_STATUS:  avs_readdata <= status_word;
                    default:      avs_readdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    wire mode_inv   = ctrl_r[`CTRL_DELAY_TYPE];
    wire curve_ieee = ctrl_r[`CTRL_CURVE] & mode_inv;
    wire force_en   = ctrl_r[`CTRL_FORCE_EN];

    ////////////////////////////////////////////////////////////////////////////
    // Pick-up comparator with hysteresis
    // Both sides are scaled by 100 so the 97 percent level needs no divide.
    // Widths grow by seven bits so no product can wrap.
    wire [MEAS_W+6:0] meas_x100  = meas_value * 7'd100;
    wire [MEAS_W+6:0] reset_lim  = setting_r * 7'd97;
    wire [MEAS_W+6:0] pick_lim   = setting_r * 7'd100;
    wire              above_pick = meas_x100 >= pick_lim;
    wire              above_rst  = meas_x100 >= reset_lim;

    // Sampled blocking, with software drive only in test mode
    // Blocking is taken only at cycle start, so a late change waits a
    // whole program cycle; its source must lead the delay by that margin.
    reg  block_r;
    wire block_src = ctrl_r[`CTRL_TEST_MODE] ? ctrl_r[`CTRL_TEST_BLK] : block_in;

    always @(posedge ref_clk) begin
        if (rst) begin
            pickup_r <= 1'b0;
            block_r  <= 1'b0;
        end else begin
            if (cycle_start)
                block_r <= block_src;
            pickup_r <= pickup_r ? above_rst : above_pick;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Operating delay in clock cycles
    // Inverse delay approximated by a shift law: delay grows as the
    // overshoot shrinks; the curve families differ only in scale, IEEE four times IEC.
    // Limitation: this is a coarse stand-in, not a standard curve.
    // The 48-bit timer covers the longest step setting at full clock rate.
    // Simulation may shrink the step length to keep runs short.
    reg  [INV_SHIFT_W-1:0] ratio_log;
    reg  [47:0]            target_cyc;
    reg  [47:0]            fixed_cyc;
    reg  [47:0]            inv_cyc;
    integer                i;

    // One comparator per bit position of the ratio
    wire [MEAS_W-1:0] ratio_hit;
    genvar g;
    generate
        for (g = 0; g < MEAS_W; g = g + 1) begin : g_ratio
            // Does the measurement reach the setting scaled by 2^g?
            assign ratio_hit[g] = ((meas_value >> g) >= setting_r) && (setting_r != 32'h0000_0000);
        end
    endgenerate

    // Leading hit gives a coarse log2 of measurement over setting
    always @* begin
        ratio_log = {INV_SHIFT_W{1'b0}};
        for (i = 0; i < MEAS_W; i = i + 1) begin
            if (ratio_hit[i])
                ratio_log = i[INV_SHIFT_W-1:0];
        end
        fixed_cyc = delay_r * STEP_CYC_W;
        inv_cyc   = (48'd1 << (curve_ieee ? 6'd30 : 6'd28)) >> ratio_log;
        if (!mode_inv)
            target_cyc = fixed_cyc;
        else
            target_cyc = (inv_cyc < fixed_cyc) ? fixed_cyc : inv_cyc;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Start, trip and inhibit state machine
    // Blocking that cuts a started occurrence short parks it in ST_BLK,
    // so one occurrence never yields two blocking events.
    // The fault code is latched with the event strobe, in the same cycle that
    // start and trip are cleared, so the record shows where blocking struck.
    reg  [47:0] timer_r;
    reg         blk_evt;
    reg  [1:0]  blk_fault;
    wire        go       = pickup_r & ~block_r;
    wire        instant  = ~mode_inv & (delay_r == 16'h0000);
    wire        time_up  = (timer_r + 48'd1) >= target_cyc;
    wire        drop     = ~pickup_r;

    always @(posedge ref_clk) begin
        if (rst) begin
            state_r                <= ST_IDLE;
            timer_r                <= 48'h0;
            start_r                <= 1'b0;
            trip_r                 <= 1'b0;
            inhibited_indication_r <= 1'b0;
            blk_evt                <= 1'b0;
            blk_fault              <= 2'b00;
        end else begin
            // Event strobe is a single-cycle pulse
            blk_evt <= 1'b0;
            case (state_r)
                // Waiting for pick-up; blocking decides start or inhibit
                ST_IDLE: begin
                    timer_r                <= 48'h0;
                    inhibited_indication_r <= 1'b0;
                    start_r                <= 1'b0;
                    trip_r                 <= 1'b0;
                    if (pickup_r && block_r) begin
                        state_r                <= ST_BLK;
                        inhibited_indication_r <= 1'b1;
                        blk_evt                <= 1'b1;
                        blk_fault              <= 2'b00;   // Inhibited_indication at pick-up
                    end else if (go) begin
                        start_r <= 1'b1;
                        if (instant) begin
                            trip_r  <= 1'b1;
                            state_r <= ST_TRIP;
                        end else begin
                            state_r <= ST_TIME;
                        end
                    end
                end
                // Operating timer runs while pick-up holds and nothing blocks
                ST_TIME: begin
                    if (block_r) begin
                        // Late blocking clears start and timer as a pick-up reset would, then parks in ST_BLK
                        state_r   <= ST_BLK;
                        start_r   <= 1'b0;
                        timer_r   <= 48'h0;
                        blk_evt   <= 1'b1;
                        blk_fault <= 2'b01;                // Inhibited_indication after start
                    end else if (drop) begin
                        state_r <= ST_IDLE;
                        start_r <= 1'b0;
                        timer_r <= 48'h0;
                    end else if (time_up) begin
                        trip_r  <= 1'b1;
                        state_r <= ST_TRIP;
                    end else begin
                        timer_r <= timer_r + 48'd1;
                    end
                end
                // Tripped; held until pick-up drops or blocking arrives
                ST_TRIP: begin
                    if (block_r) begin
                        state_r   <= ST_BLK;
                        start_r   <= 1'b0;
                        trip_r    <= 1'b0;
                        timer_r   <= 48'h0;
                        blk_evt   <= 1'b1;
                        blk_fault <= 2'b11;                // Inhibited_indication after trip
                    end else if (drop) begin
                        state_r <= ST_IDLE;
                        start_r <= 1'b0;
                        trip_r  <= 1'b0;
                    end
                end
                // No timing until this occurrence's pick-up has gone
                ST_BLK: begin
                    start_r <= 1'b0;
                    trip_r  <= 1'b0;
                    if (drop)
                        state_r <= ST_IDLE;
                end
                default: state_r <= ST_IDLE;
            endcase
            // Software forcing overrides the computed status while enabled
            if (force_en) begin
                if (ctrl_r[`CTRL_FORCE_ST]) start_r <= 1'b1;
                if (ctrl_r[`CTRL_FORCE_TR]) trip_r  <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Time stamp and blocking event record
    // The stamp counter wraps freely; software extends it if needed.
    // Record fields hold until the next blocking event overwrites them.
    // Notification and event pulse together, one per occurrence.
    always @(posedge ref_clk) begin
        if (rst) begin
            stamp_r       <= 32'h0000_0000;
            event_valid_r <= 1'b0;
            event_value_r <= {MEAS_W{1'b0}};
            event_stamp_r <= 32'h0000_0000;
            event_fault_r <= 2'b00;
            notify_r      <= 1'b0;
        end else begin
            stamp_r       <= stamp_r + 32'h0000_0001;
            event_valid_r <= blk_evt;
            notify_r      <= blk_evt;
            if (blk_evt) begin
                event_value_r <= meas_value;
                event_stamp_r <= stamp_r;
                event_fault_r <= blk_fault;                  // Fault type: where blocking struck
            end
        end
    end

    // Status word shows live stage state
    // It is read through the capture register, so it lags by one cycle.
    // Upper bytes read zero to leave room for later fields.
    assign status_word = {24'h000000, state_r, block_r, notify_r,
                          inhibited_indication_r, trip_r, start_r, pickup_r};

endmodule // protection_stage_timing_core

`default_nettype wire

// ### logic/stage_map.vh
// Register map, field codes and timing constants of the protection stage timing core
`ifndef STAGE_MAP_VH
`define STAGE_MAP_VH
// Register byte offsets
`define REG_CTRL        4'h0
`define REG_SETTING     4'h4
`define REG_DELAY       4'h8
`define REG_STATUS      4'hc
// Control field positions
`define CTRL_DELAY_TYPE 0
`define CTRL_CURVE      1
`define CTRL_TEST_MODE  2
`define CTRL_TEST_BLK   3
`define CTRL_FORCE_EN   4
`define CTRL_FORCE_ST   5
`define CTRL_FORCE_TR   6
`define CTRL_RESET      32'h0000_0000
// Codes
`define MODE_FIXED      1'b0
`define MODE_INVERSE    1'b1
`define CURVE_IEC       1'b0
`define CURVE_IEEE      1'b1
// Hysteresis: reset at 97/100 of setting
`define RESET_NUM       32'h0000_0061
`define RESET_DEN       32'h0000_0064
// Delay unit 5 ms step, default 8 steps = 0.040 s
`define DELAY_STEP_US   5000
`define DELAY_DEF_STEPS 16'h0008
`define CLK_MHZ         250
`define STEP_CYCLES     (`DELAY_STEP_US * `CLK_MHZ)
`define SETTING_DEF     32'h0000_1000
`endif

// ### dv/stage_checker.sv
// Port-level assertions of the protection stage
`timescale 1ns/1ps
`default_nettype none
module stage_checker #(
    parameter MEAS_W      = 32,
    parameter STEP_CYCLES = 4
) (
    // Clock, reset and register writes
    input wire logic              ref_clk,
    input wire logic              rst,
    input wire logic [3:0]        avs_address,
    input wire logic              avs_write,
    input wire logic [31:0]       avs_writedata,
    input wire logic              avs_waitrequest,
    // Measurement and blocking
    input wire logic [MEAS_W-1:0] meas_value,
    input wire logic              cycle_start,
    input wire logic              block_in,
    // Stage outputs
    input wire logic              pickup_r,
    input wire logic              start_r,
    input wire logic              trip_r,
    input wire logic              inhibited_indication_r,
    input wire logic              event_valid_r,
    input wire logic              notify_r
);
    logic [31:0] set_r;
    logic [15:0] dly_r;
    logic        mode_r;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Shadow of the settings; the bench only issues full-word writes
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            set_r  <= 32'h0000_1000;
            dly_r  <= 16'h0008;
            mode_r <= 1'b0;
        end else if (avs_write && !avs_waitrequest) begin
            if (avs_address == 4'h4) set_r <= avs_writedata;
            if (avs_address == 4'h8) dly_r <= avs_writedata[15:0];
            if (avs_address == 4'h0) mode_r <= avs_writedata[0];
        end
    end
    ////////////////////////////////////////
    sequence s_start_seen;
        $rose(start_r);
    endsequence
    sequence s_instant;
        s_start_seen ##0 (!mode_r && dly_r == 16'h0000);
    endsequence
    a_pickup_rise: assert property ($rose(pickup_r) |-> $past(meas_value) >= $past(set_r))
        else $error("pick-up rose below setting");
    a_pickup_fall: assert property ($fell(pickup_r) |-> 64'd100 * $past(meas_value) < 64'd97 * $past(set_r))
        else $error("pick-up fell above reset level");
    a_hyst_hold: assert property (pickup_r && 64'd100 * meas_value >= 64'd97 * set_r |=> pickup_r)
        else $error("pick-up lost inside hysteresis");
    a_start_cause: assert property (s_start_seen |-> $past(pickup_r) && !inhibited_indication_r)
        else $error("start without clean pick-up");
    a_inhib_quiet: assert property (inhibited_indication_r && $past(inhibited_indication_r) |-> !start_r && !trip_r)
        else $error("timing while inhibited");
    a_instant_trip: assert property (s_instant |-> trip_r)
        else $error("zero delay did not trip with start");
    a_trip_cause: assert property ($rose(trip_r) |-> start_r)
        else $error("trip without start");
    a_late_block: assert property (start_r && cycle_start && block_in |-> ##[1:3] !start_r)
        else $error("blocking did not clear start");
    a_event_pulse: assert property (event_valid_r |-> notify_r ##1 !event_valid_r)
        else $error("event pulse malformed");
endmodule // stage_checker
bind protection_stage_timing_core stage_checker #(.MEAS_W(MEAS_W), .STEP_CYCLES(STEP_CYCLES)) u_chk (
    .ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest), .meas_value(meas_value),
    .cycle_start(cycle_start), .block_in(block_in), .pickup_r(pickup_r), .start_r(start_r),
    .trip_r(trip_r), .inhibited_indication_r(inhibited_indication_r),
    .event_valid_r(event_valid_r), .notify_r(notify_r));
`default_nettype wire

// ### dv/front_end_model.sv
// Model of the measurement front end and blocking matrix
`timescale 1ns/1ps
`default_nettype none
module front_end_model #(
    parameter CYC = 8
) (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Requests from the bench
    input  wire logic [31:0] meas_req,
    input  wire logic        blk_req,
    // Toward the stage
    output var  logic [31:0] meas_value,
    output var  logic        cycle_start,
    output var  logic        block_in
);
    logic [7:0] cnt_r;
    // Program cycle tick; blocking only moves on it, well ahead of any delay
    always_ff @(posedge ref_clk) begin
        cnt_r       <= (rst || cnt_r == 8'(CYC - 1)) ? 8'h00 : cnt_r + 8'h01;
        cycle_start <= !rst && cnt_r == 8'(CYC - 1);
        meas_value  <= meas_req;
        if (rst) block_in <= 1'b0;
        else if (cnt_r == 8'(CYC - 1)) block_in <= blk_req;
    end
endmodule // front_end_model
`default_nettype wire

// ### dv/tb_top.sv
// Self-checking bench of the protection stage timing core
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        ref_clk, rst, avs_read, avs_write, avs_waitrequest, blk_req, cycle_start, block_in;
    logic        pickup_r, start_r, trip_r, inhibited_indication_r, event_valid_r, notify_r;
    logic [3:0]  avs_address;
    logic [1:0]  event_fault_r;
    logic [31:0] avs_writedata, avs_readdata, meas_req, meas_value, event_value_r, event_stamp_r;
    logic [31:0] rq[$], eq[$];
    logic [7:0]  lf;
    int          error_cnt, compares, cycles, n, c;
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    protection_stage_timing_core #(.STEP_CYCLES(4)) u_protection_stage_timing_core (
        .ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .meas_value(meas_value),
        .cycle_start(cycle_start), .block_in(block_in), .pickup_r(pickup_r), .start_r(start_r),
        .trip_r(trip_r), .inhibited_indication_r(inhibited_indication_r),
        .event_valid_r(event_valid_r), .event_value_r(event_value_r),
        .event_stamp_r(event_stamp_r), .event_fault_r(event_fault_r), .notify_r(notify_r));
    front_end_model u_front_end_model (.ref_clk(ref_clk), .rst(rst), .meas_req(meas_req),
        .blk_req(blk_req), .meas_value(meas_value), .cycle_start(cycle_start), .block_in(block_in));
    ////////////////////////////////////////
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic flag(input logic b);
        chk({31'h0, b}, 32'h1);
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge ref_clk);
    endtask
    // Bus cycle held until waitrequest is seen low, then released
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        cyc(1);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        rq.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    task automatic go(input logic [31:0] m, input logic b);
        meas_req <= m;
        blk_req <= b;
        cyc(1);
    endtask
    task automatic run(input logic [31:0] m);
        go(m, 1'b0);
        n = 0;
        while (start_r !== 1'b1) cyc(1);
        while (trip_r !== 1'b1 && n < 3000) begin
            cyc(1);
            n++;
        end
    endtask
    task automatic end_sim;
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////
    // Result watchers: each read or event takes the oldest note
    always @(posedge ref_clk) begin
        if (avs_read && avs_waitrequest === 1'b0) chk(avs_readdata, rq.pop_front());
        if (event_valid_r === 1'b1) chk({30'h0, event_fault_r}, eq.pop_front());
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            end_sim;
        end
    end
    // Main sequence
    initial begin
        rst = 1'b1;
        {avs_read, avs_write, avs_address, avs_writedata, meas_req, blk_req} = '0;
        lf = 8'd23;
        cyc(20);
        rst <= 1'b0;
        cyc(1);
        rd(4'h0, 32'h0);
        rd(4'h4, 32'h1000);
        rd(4'h8, 32'h8);
        bus(1'b1, 4'h2, 32'hffff_ffff);
        rd(4'h2, 32'h0);
        bus(1'b1, 4'h8, 32'hffff_0003);
        rd(4'h8, 32'h3);
        bus(1'b1, 4'h0, 32'hffff_ff80);
        rd(4'h0, 32'h0);
        $display("registers done");
        bus(1'b1, 4'h4, 32'd1000);
        bus(1'b1, 4'h8, 32'h0);
        lf = lfsr(lf);
        run(32'd1000 + {24'h0, lf});
        flag(n == 0);
        go(32'd970, 1'b0);
        cyc(4);
        flag(pickup_r === 1'b1);
        go(32'd969, 1'b0);
        cyc(4);
        flag({pickup_r, start_r, trip_r} === 3'b000);
        $display("instant and hysteresis done");
        bus(1'b1, 4'h8, 32'h3);
        run(32'd2000);
        flag(n >= 11 && n <= 13);
        go(32'h0, 1'b0);
        bus(1'b1, 4'h8, 32'h8);
        go(32'd2000, 1'b0);
        cyc(10);
        go(32'h0, 1'b0);
        n = 0;
        repeat (40) begin
            cyc(1);
            if (trip_r !== 1'b0) n++;
        end
        flag(n == 0 && start_r === 1'b0);
        $display("fixed delay done");
        go(32'h0, 1'b1);
        cyc(10);
        eq.push_back(32'h0);
        go(32'd2000, 1'b1);
        cyc(4);
        flag(inhibited_indication_r === 1'b1 && start_r === 1'b0);
        cyc(40);
        flag(trip_r === 1'b0);
        go(32'h0, 1'b0);
        cyc(12);
        go(32'd2000, 1'b0);
        while (start_r !== 1'b1) cyc(1);
        eq.push_back(32'h1);
        blk_req <= 1'b1;
        cyc(12);
        flag(start_r === 1'b0);
        cyc(30);
        flag(trip_r === 1'b0);
        go(32'h0, 1'b0);
        cyc(12);
        bus(1'b1, 4'h0, 32'hc);
        cyc(10);
        eq.push_back(32'h0);
        go(32'd2000, 1'b0);
        cyc(6);
        flag(inhibited_indication_r === 1'b1 && start_r === 1'b0);
        go(32'h0, 1'b0);
        bus(1'b1, 4'h0, 32'h0);
        cyc(10);
        $display("blocking done");
        bus(1'b1, 4'h4, 32'h1);
        bus(1'b1, 4'h8, 32'd20);
        for (c = 0; c < 2; c++) begin
            bus(1'b1, 4'h0, {30'h0, c[0], 1'b1});
            run(32'h8000_0000);
            flag(n >= 78 && n <= 82);
            go(32'h0, 1'b0);
            cyc(6);
        end
        bus(1'b1, 4'h8, 32'h0);
        run(32'h0004_0000);
        flag(n > 100);
        go(32'h0, 1'b0);
        cyc(6);
        $display("inverse done");
        end_sim;
    end
endmodule // tb_top
`default_nettype wire
